// File: sram_bwm_pkg.sv
// constants, types and lane decoding for the byte-lane masked sram write port
package sram_bwm_pkg;

   localparam int LANE_W  = 9;
   localparam int LANES   = 4;
   localparam int WORD_W  = LANE_W * LANES;
   localparam int ADDR_W  = 10;
   localparam int WADDR_W = ADDR_W + 1;
   localparam int DEPTH   = 1 << WADDR_W;

   localparam int AV_ADDR_W = 5;
   localparam int AV_DATA_W = 32;
   localparam logic [AV_ADDR_W-1:0] OFF_CTRL      = 5'h00;
   localparam logic [AV_ADDR_W-1:0] OFF_STATUS    = 5'h04;
   localparam logic [AV_ADDR_W-1:0] OFF_BURSTS    = 5'h08;
   localparam logic [AV_ADDR_W-1:0] OFF_MASKED    = 5'h0C;
   localparam logic [AV_ADDR_W-1:0] OFF_LAST_ADDR = 5'h10;

   localparam int CTRL_W         = 3;
   localparam int CTRL_X36_BIT   = 0;
   localparam int CTRL_WR_EN_BIT = 1;
   localparam int CTRL_RD_EN_BIT = 2;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h7;

   localparam int ST_WR_BUSY = 0;
   localparam int ST_RD_BUSY = 1;
   localparam int ST_PHASE   = 2;
   localparam int ST_OE      = 3;

   localparam int SYNC_W = 2 + ADDR_W + LANES + WORD_W;
   localparam logic [SYNC_W-1:0] SYNC_RESET = {2'b11, {(SYNC_W-2){1'b0}}};

   typedef enum logic [2:0]
   {
      WR_IDLE   = 3'b001,
      WR_SECOND = 3'b010,
      WR_COMMIT = 3'b100
   } wr_state_t;

   // active-high lane write enables from the active-low lane selects
   function automatic logic [LANES-1:0] lane_we(input logic [LANES-1:0] mask_n,
                                               input logic             x36);
      // x18 leaves lanes 2 and 3 without an enable whatever their selects say
      lane_we = x36 ? ~mask_n
                    : {2'b00, ~mask_n[1:0]};
   endfunction

endpackage

// File: lane_ram.sv
// memory array with one write port gated per byte lane and one read port
`timescale 1ns/100ps
module lane_ram
(
   input  wire logic                                 clk_i,
   input  wire logic [sram_bwm_pkg::LANES-1:0]       we_i,
   input  wire logic [sram_bwm_pkg::WADDR_W-1:0]     waddr_i,
   input  wire logic [sram_bwm_pkg::WORD_W-1:0]      wdata_i,
   input  wire logic [sram_bwm_pkg::WADDR_W-1:0]     raddr_i,
   output logic      [sram_bwm_pkg::WORD_W-1:0]      rdata_o
);

   ////////////////////////////////////////////////////////////////////////////
   // one array per lane, a lane without its enable keeps its stored byte
   genvar g;
   generate
      for (g = 0; g < sram_bwm_pkg::LANES; g = g + 1)
      begin : g_lane
         logic [sram_bwm_pkg::LANE_W-1:0] mem [sram_bwm_pkg::DEPTH];

         always_ff @(posedge clk_i)
         begin
            if (we_i[g])
            begin
               mem[waddr_i] <= wdata_i[g*sram_bwm_pkg::LANE_W +: sram_bwm_pkg::LANE_W];
            end
         end

         assign rdata_o[g*sram_bwm_pkg::LANE_W +: sram_bwm_pkg::LANE_W] = mem[raddr_i];
      end
   endgenerate

endmodule // lane_ram

// File: sram_byte_write_mask.sv
// sram write port with per-word byte-lane masking, burst read port and register bus
`timescale 1ns/100ps
module sram_byte_write_mask
(
   input  wire logic                                   clk_i,
   input  wire logic                                   reset_i,
   input  wire logic                                   write_port_select_n_i,
   input  wire logic                                   read_port_select_n_i,
   input  wire logic [sram_bwm_pkg::ADDR_W-1:0]        addr_i,
   input  wire logic [sram_bwm_pkg::WORD_W-1:0]        data_i,
   input  wire logic [sram_bwm_pkg::LANES-1:0]         byte_lane_mask_n_i,
   output logic      [sram_bwm_pkg::WORD_W-1:0]        q_o,
   output logic                                        q_oe_o,
   input  wire logic [sram_bwm_pkg::AV_ADDR_W-1:0]     avs_address_i,
   input  wire logic                                   avs_read_i,
   input  wire logic                                   avs_write_i,
   input  wire logic [sram_bwm_pkg::AV_DATA_W-1:0]     avs_writedata_i,
   input  wire logic [3:0]                             avs_byteenable_i,
   output logic      [sram_bwm_pkg::AV_DATA_W-1:0]     avs_readdata_o,
   output logic                                        avs_waitrequest_o
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: two flops before anything looks at the pins; selects,
   // address, masks and data share both stages, so a mask always arrives in the
   // same cycle as the word it qualifies

   logic [sram_bwm_pkg::SYNC_W-1:0] pin_meta_reg;
   logic [sram_bwm_pkg::SYNC_W-1:0] pin_sync_reg;

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         pin_meta_reg <= sram_bwm_pkg::SYNC_RESET;
         pin_sync_reg <= sram_bwm_pkg::SYNC_RESET;
      end
      else
      begin
         pin_meta_reg <= {write_port_select_n_i, read_port_select_n_i, addr_i,
                          byte_lane_mask_n_i, data_i};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   wire                                wps_n_s;
   wire                                rps_n_s;
   wire [sram_bwm_pkg::ADDR_W-1:0]     addr_s;
   wire [sram_bwm_pkg::LANES-1:0]      mask_n_s;
   wire [sram_bwm_pkg::WORD_W-1:0]     data_s;

   assign {wps_n_s, rps_n_s, addr_s, mask_n_s, data_s} = pin_sync_reg;

   ////////////////////////////////////////////////////////////////////////////
   // clock phase: even cycles stand for the true clock edge, odd ones for the
   // complementary edge; port selects are looked at on the true edge only
   // the phase restarts with reset, so the first cycle after release is a true edge

   logic k_bar_phase_reg;

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         k_bar_phase_reg <= 1'b0;
      else
         k_bar_phase_reg <= ~k_bar_phase_reg;
   end

   ////////////////////////////////////////////////////////////////////////////
   // control registers

   logic [sram_bwm_pkg::CTRL_W-1:0]    ctrl_reg;
   logic [31:0]                        bursts_reg;
   logic [31:0]                        masked_reg;
   logic [sram_bwm_pkg::ADDR_W-1:0]    last_addr_reg;

   wire ctrl_x36   = ctrl_reg[sram_bwm_pkg::CTRL_X36_BIT];
   wire ctrl_wr_en = ctrl_reg[sram_bwm_pkg::CTRL_WR_EN_BIT];
   wire ctrl_rd_en = ctrl_reg[sram_bwm_pkg::CTRL_RD_EN_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // write port

   sram_bwm_pkg::wr_state_t wr_state_reg;
   sram_bwm_pkg::wr_state_t wr_state_next;

   logic [sram_bwm_pkg::WORD_W-1:0]    d0_reg;
   logic [sram_bwm_pkg::WORD_W-1:0]    d1_reg;
   logic [sram_bwm_pkg::LANES-1:0]     m0_reg;
   logic [sram_bwm_pkg::LANES-1:0]     m1_reg;
   logic [sram_bwm_pkg::ADDR_W-1:0]    wa_reg;

   // a burst only begins on a true edge with the select low
   wire wr_start = ~k_bar_phase_reg & ~wps_n_s & ctrl_wr_en;
   wire wr_word0 = (wr_state_reg == sram_bwm_pkg::WR_SECOND);
   wire wr_word1 = (wr_state_reg == sram_bwm_pkg::WR_COMMIT);

   always_comb
   begin
      case (wr_state_reg)
         sram_bwm_pkg::WR_IDLE:
            wr_state_next = wr_start ? sram_bwm_pkg::WR_SECOND : sram_bwm_pkg::WR_IDLE;
         sram_bwm_pkg::WR_SECOND:
            wr_state_next = sram_bwm_pkg::WR_COMMIT;
         sram_bwm_pkg::WR_COMMIT:
            wr_state_next = wr_start ? sram_bwm_pkg::WR_SECOND : sram_bwm_pkg::WR_IDLE;
         default:
            wr_state_next = sram_bwm_pkg::WR_IDLE;
      endcase
   end

   // first word and its mask on the true edge, second on the complementary one
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         wr_state_reg <= sram_bwm_pkg::WR_IDLE;
         d0_reg       <= '0;
         m0_reg       <= '1;
         d1_reg       <= '0;
         m1_reg       <= '1;
         wa_reg       <= '0;
      end
      else
      begin
         wr_state_reg <= wr_state_next;
         if (wr_start)
         begin
            d0_reg <= data_s;
            m0_reg <= mask_n_s;
         end
         if (wr_word0)
         begin
            d1_reg <= data_s;
            m1_reg <= mask_n_s;
            wa_reg <= addr_s;
         end
      end
   end

   // the address is latched on the complementary edge, so word 0 is committed
   // then and word 1 on the next true edge; a new burst may overlap the commit
   wire [sram_bwm_pkg::LANES-1:0]   mem_we;
   wire [sram_bwm_pkg::WADDR_W-1:0] mem_waddr;
   wire [sram_bwm_pkg::WORD_W-1:0]  mem_wdata;
   wire [sram_bwm_pkg::LANES-1:0]   we_word0;
   wire [sram_bwm_pkg::LANES-1:0]   we_word1;
   wire [sram_bwm_pkg::LANES-1:0]   we_all;

   // each word decodes its own mask; a lane without enable keeps its stored byte
   assign we_word0  = sram_bwm_pkg::lane_we(m0_reg, ctrl_x36);
   assign we_word1  = sram_bwm_pkg::lane_we(m1_reg, ctrl_x36);
   // x18 leaves lanes 2 and 3 idle, so two lanes already make a full word
   assign we_all    = ctrl_x36 ? 4'hF : 4'h3;

   // nothing reaches the array outside a burst that a valid select started
   assign mem_we    = wr_word0 ? we_word0 :
                      wr_word1 ? we_word1 :
                      4'h0;
   assign mem_waddr = wr_word0 ? {addr_s, 1'b0} : {wa_reg, 1'b1};
   assign mem_wdata = wr_word0 ? d0_reg : d1_reg;

   // a word counts as masked when any lane it could write stays unwritten
   wire word_masked = (wr_word0 | wr_word1) & (mem_we != we_all);

   ////////////////////////////////////////////////////////////////////////////
   // read port: word 0 of A on the complementary edge, word 1 of A on the next true edge
   // no forwarding: a read in the cycle that commits the same location sees the old word

   logic                               rd0_pend_reg;
   logic                               rd1_pend_reg;
   logic [sram_bwm_pkg::ADDR_W-1:0]    ra_reg;
   logic [sram_bwm_pkg::WORD_W-1:0]    q_reg;
   logic                               q_oe_reg;

   wire                                rd_start = ~k_bar_phase_reg & ~rps_n_s & ctrl_rd_en;
   wire [sram_bwm_pkg::WADDR_W-1:0]    mem_raddr = {ra_reg, rd1_pend_reg};
   wire [sram_bwm_pkg::WORD_W-1:0]     mem_rdata;
   wire                                rd_launch = rd0_pend_reg | rd1_pend_reg;

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rd0_pend_reg <= 1'b0;
         rd1_pend_reg <= 1'b0;
         ra_reg       <= '0;
         q_reg        <= '0;
         q_oe_reg     <= 1'b0;
      end
      else
      begin
         rd0_pend_reg <= rd_start;
         rd1_pend_reg <= rd0_pend_reg;
         if (rd_start)
            ra_reg <= addr_s;
         if (rd_launch)
            q_reg <= mem_rdata;
         q_oe_reg <= rd_launch;
      end
   end

   assign q_o    = q_reg;
   assign q_oe_o = q_oe_reg;

   lane_ram u_ram
   (
      .clk_i   (clk_i),
      .we_i    (mem_we),
      .waddr_i (mem_waddr),
      .wdata_i (mem_wdata),
      .raddr_i (mem_raddr),
      .rdata_o (mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // avalon slave: every access waits exactly one cycle
   // waitrequest idles high, which costs a cycle per access but lets the read
   // mux settle for a whole cycle before the registered answer

   function automatic logic hit(input logic [sram_bwm_pkg::AV_ADDR_W-1:0] a,
                                input logic [sram_bwm_pkg::AV_ADDR_W-1:0] off);
      hit = (a == off);
   endfunction

   logic                               waitreq_reg;
   logic [sram_bwm_pkg::AV_DATA_W-1:0] rdata_reg;

   wire av_req      = avs_read_i | avs_write_i;
   wire av_first    = av_req & waitreq_reg;
   wire av_commit   = avs_write_i & ~waitreq_reg;
   // the control word only listens to byte 0 of the bus word
   wire wr_ctrl     = av_commit & hit(avs_address_i, sram_bwm_pkg::OFF_CTRL) &
                      avs_byteenable_i[0];
   wire clr_bursts  = av_commit & hit(avs_address_i, sram_bwm_pkg::OFF_BURSTS);
   wire clr_masked  = av_commit & hit(avs_address_i, sram_bwm_pkg::OFF_MASKED);

   wire [3:0] status_word;
   assign status_word[sram_bwm_pkg::ST_WR_BUSY] = (wr_state_reg != sram_bwm_pkg::WR_IDLE);
   assign status_word[sram_bwm_pkg::ST_RD_BUSY] = rd_launch;
   assign status_word[sram_bwm_pkg::ST_PHASE]   = k_bar_phase_reg;
   assign status_word[sram_bwm_pkg::ST_OE]      = q_oe_reg;

   // unmapped offsets read as zero and ignore writes
   wire [sram_bwm_pkg::AV_DATA_W-1:0] rd_mux =
      hit(avs_address_i, sram_bwm_pkg::OFF_CTRL)      ? {29'h0, ctrl_reg}          :
      hit(avs_address_i, sram_bwm_pkg::OFF_STATUS)    ? {28'h0, status_word}       :
      hit(avs_address_i, sram_bwm_pkg::OFF_BURSTS)    ? bursts_reg                 :
      hit(avs_address_i, sram_bwm_pkg::OFF_MASKED)    ? masked_reg                 :
      hit(avs_address_i, sram_bwm_pkg::OFF_LAST_ADDR) ? {22'h0, last_addr_reg}     :
      32'h0;

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         waitreq_reg <= 1'b1;
         rdata_reg   <= '0;
      end
      else
      begin
         waitreq_reg <= ~av_first;
         if (av_first && avs_read_i)
            rdata_reg <= rd_mux;
      end
   end

   assign avs_waitrequest_o = waitreq_reg;
   assign avs_readdata_o    = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // configuration and counters; a count event and a clear in the same cycle leave the count at one

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         ctrl_reg      <= sram_bwm_pkg::CTRL_RESET;
         bursts_reg    <= '0;
         masked_reg    <= '0;
         last_addr_reg <= '0;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_reg <= avs_writedata_i[sram_bwm_pkg::CTRL_W-1:0];
         if (wr_word0)
         begin
            bursts_reg    <= (clr_bursts ? 32'h0 : bursts_reg) + 32'h1;
            last_addr_reg <= addr_s;
         end
         else if (clr_bursts)
            bursts_reg <= '0;
         if (word_masked)
            masked_reg <= (clr_masked ? 32'h0 : masked_reg) + 32'h1;
         else if (clr_masked)
            masked_reg <= '0;
      end
   end

endmodule // sram_byte_write_mask

// File: sram_byte_write_mask_asserts.sv
// port-level properties of the byte-lane masked sram block
`timescale 1ns/100ps
module sram_byte_write_mask_asserts
(
   input wire logic        clk_i,
   input wire logic        reset_i,
   input wire logic        write_port_select_n_i,
   input wire logic        q_oe_o,
   input wire logic [4:0]  avs_address_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic        avs_waitrequest_o
);
   wire       req      = avs_read_i | avs_write_i;
   wire       unmapped = avs_address_i > sram_bwm_pkg::OFF_LAST_ADDR;
   logic [3:0] oe_run_reg;

   // length of the current run of driven read words, folded so that a long
   // run of back to back reads keeps its parity and never reads as zero
   always_ff @(posedge clk_i or posedge reset_i)
      if (reset_i)
         oe_run_reg <= 4'h0;
      else if (q_oe_o)
         oe_run_reg <= (oe_run_reg == 4'hE) ? 4'h1 : oe_run_reg + 4'h1;
      else
         oe_run_reg <= 4'h0;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   property p_reset_quiet; $fell(reset_i) |-> !q_oe_o [*3]; endproperty
   property p_oe_pair; $rose(q_oe_o) |=> q_oe_o; endproperty
   property p_oe_even; $fell(q_oe_o) |-> oe_run_reg[0] == 1'b0 && oe_run_reg != 4'h0; endproperty
   property p_wait_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
   property p_wait_answer; req && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
   property p_wait_cause; !avs_waitrequest_o |-> $past(avs_read_i) || $past(avs_write_i); endproperty
   property p_idle_wait; (!req) [*2] |-> avs_waitrequest_o; endproperty
   property p_unmapped; avs_read_i && !avs_waitrequest_o && unmapped |-> avs_readdata_o == 32'h0;
   endproperty

   a_reset_quiet: assert property (p_reset_quiet) else $error("read port driven after reset");
   a_oe_pair: assert property (p_oe_pair) else $error("read burst shorter than two words");
   a_oe_even: assert property (p_oe_even) else $error("odd count of read words");
   a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
   a_wait_answer: assert property (p_wait_answer) else $error("bus access not answered");
   a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
   a_idle_wait: assert property (p_idle_wait) else $error("waitrequest low at idle");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   c_read: cover property ($rose(q_oe_o));
   c_write: cover property (!write_port_select_n_i);
   c_bus_write: cover property (avs_write_i && !avs_waitrequest_o);
endmodule // sram_byte_write_mask_asserts

bind sram_byte_write_mask sram_byte_write_mask_asserts u_chk
(
   .clk_i(clk_i), .reset_i(reset_i), .write_port_select_n_i(write_port_select_n_i),
   .q_oe_o(q_oe_o), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o)
);

// File: mem_ctrl_model.sv
// memory controller model driving the write and read pins of the sram block
`timescale 1ns/100ps
module mem_ctrl_model
(
   input  wire logic        clk_i,
   input  wire logic        odd_i,
   output logic             wsel_n_o,
   output logic             rsel_n_o,
   output logic [9:0]       addr_o,
   output logic [35:0]      data_o,
   output logic [3:0]       mask_n_o
);
   initial
   begin
      wsel_n_o = 1'b1;
      rsel_n_o = 1'b1;
      addr_o   = 10'h000;
      data_o   = 36'h0;
      mask_n_o = 4'hF;
   end

   // selects are only honoured on true edges, so start just before one
   task automatic slot();
      do
         @(posedge clk_i);
      while (!odd_i);
   endtask

   task automatic wr(input logic [9:0] a, input logic [35:0] d0, input logic [3:0] m0,
                     input logic [35:0] d1, input logic [3:0] m1);
      slot();
      wsel_n_o <= 1'b0;
      data_o   <= d0;
      mask_n_o <= m0;
      @(posedge clk_i);
      wsel_n_o <= 1'b1;
      addr_o   <= a;
      data_o   <= d1;
      mask_n_o <= m1;
      @(posedge clk_i);
      // released lines show the inverse, never the last value
      addr_o   <= ~a;
      data_o   <= ~d1;
      mask_n_o <= ~m1;
   endtask

   task automatic rd(input logic [9:0] a);
      slot();
      rsel_n_o <= 1'b0;
      addr_o   <= a;
      @(posedge clk_i);
      rsel_n_o <= 1'b1;
      addr_o   <= ~a;
   endtask
endmodule // mem_ctrl_model

// File: sram_byte_write_mask_bench.sv
// self-checking bench for the byte-lane masked sram block
`timescale 1ns/100ps
module sram_byte_write_mask_bench;
   logic        clk_i, reset_i, odd, wsel_n, rsel_n, q_oe_o;
   logic        avs_read_i, avs_write_i, avs_waitrequest_o;
   logic [4:0]  avs_address_i;
   logic [31:0] avs_writedata_i, avs_readdata_o;
   logic [35:0] q_o, data_w;
   logic [9:0]  addr_w;
   logic [3:0]  mask_w;
   logic [35:0] sh [2048];
   logic [35:0] q [$];
   logic [31:0] aq [$];
   logic        x36 = 1'b1;
   logic        wen = 1'b1;
   logic        clk_run = 1'b1;
   int          n_fail = 0;
   int          compares = 0;

   initial
   begin
      clk_i = 1'b0;
      // a stopped clock is parked high
      forever #10 clk_i = clk_run ? ~clk_i : 1'b1;
   end

   always @(posedge clk_i)
      odd <= reset_i ? 1'b0 : ~odd;

   sram_byte_write_mask u_sram_byte_write_mask
   (
      .clk_i(clk_i), .reset_i(reset_i), .write_port_select_n_i(wsel_n),
      .read_port_select_n_i(rsel_n), .addr_i(addr_w), .data_i(data_w),
      .byte_lane_mask_n_i(mask_w), .q_o(q_o), .q_oe_o(q_oe_o),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o)
   );

   mem_ctrl_model u_mem_ctrl_model
   (
      .clk_i(clk_i), .odd_i(odd), .wsel_n_o(wsel_n), .rsel_n_o(rsel_n),
      .addr_o(addr_w), .data_o(data_w), .mask_n_o(mask_w)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   function automatic logic [35:0] mrg(input logic [35:0] o, d, input logic [3:0] m);
      for (int i = 0; i < 4; i++)
         if (!m[i] && (x36 || i < 2))
            o[9*i +: 9] = d[9*i +: 9];
      return o;
   endfunction

   task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      avs_address_i   <= a;
      avs_write_i     <= w;
      avs_read_i      <= !w;
      avs_writedata_i <= d;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (avs_waitrequest_o !== 1'b0 && n < 20);
      if (n >= 20)
      begin
         n_fail++;
         finish_test();
      end
      avs_read_i  <= 1'b0;
      avs_write_i <= 1'b0;
   endtask

   task automatic wrx(input int a, input logic [3:0] m0, m1);
      logic [35:0] d0, d1;
      d0 = 36'({$urandom(), $urandom()});
      d1 = 36'({$urandom(), $urandom()});
      if (wen)
      begin
         sh[{10'(a), 1'b0}] = mrg(sh[{10'(a), 1'b0}], d0, m0);
         sh[{10'(a), 1'b1}] = mrg(sh[{10'(a), 1'b1}], d1, m1);
      end
      u_mem_ctrl_model.wr(10'(a), d0, m0, d1, m1);
   endtask

   task automatic rdx(input int a);
      q.push_back(sh[{10'(a), 1'b0}]);
      q.push_back(sh[{10'(a), 1'b1}]);
      u_mem_ctrl_model.rd(10'(a));
   endtask

   // results are matched in arrival order against the notes of the drivers
   always @(posedge clk_i)
   begin
      if (q_oe_o === 1'b1)
         chk(q_o, q.pop_front());
      if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0)
         chk(36'(avs_readdata_o), 36'(aq.pop_front()));
   end

   initial
   begin
      #2000000;
      n_fail++;
      finish_test();
   end

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(31));
      reset_i = 1'b1;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_address_i = 5'h00;
      avs_writedata_i = 32'h0;
      repeat (5) @(posedge clk_i);
      reset_i <= 1'b0;
      @(posedge clk_i);
      chk(36'(q_oe_o), 36'h0);
      aq.push_back(32'h7);
      av(1'b0, sram_bwm_pkg::OFF_CTRL, 32'h0);
      av(1'b1, 5'h14, 32'hFFFFFFFF);
      aq.push_back(32'h0);
      av(1'b0, 5'h14, 32'h0);
      av(1'b1, sram_bwm_pkg::OFF_BURSTS, 32'h0);
      for (int i = 0; i < 12; i++)
         wrx(i, 4'h0, 4'h0);
      for (int i = 0; i < 4; i++)
         wrx(i, 4'hF ^ (4'h1 << i), 4'hF ^ (4'h1 << ((i + 1) % 4)));
      wrx(4, 4'hF, 4'hF);
      // park the clock high for a while; stored words must survive the pause
      clk_run = 1'b0;
      #300;
      clk_run = 1'b1;
      for (int i = 0; i < 12; i++)
         rdx(i);
      aq.push_back(32'h11);
      av(1'b0, sram_bwm_pkg::OFF_BURSTS, 32'h0);
      // writes refused while disabled
      av(1'b1, sram_bwm_pkg::OFF_CTRL, 32'h5);
      wen = 1'b0;
      wrx(0, 4'h0, 4'h0);
      rdx(0);
      av(1'b1, sram_bwm_pkg::OFF_CTRL, 32'h6);
      wen = 1'b1;
      x36 = 1'b0;
      for (int i = 0; i < 4; i++)
         wrx(8 + i, {2'b00, 2'(i)}, {2'b00, ~2'(i)});
      for (int i = 8; i < 12; i++)
         rdx(i);
      aq.push_back(32'h10);
      av(1'b0, sram_bwm_pkg::OFF_MASKED, 32'h0);
      aq.push_back(32'hB);
      av(1'b0, sram_bwm_pkg::OFF_LAST_ADDR, 32'h0);
      for (int n = 0; n < 100 && q.size() > 0; n++)
         @(posedge clk_i);
      chk(36'(q.size()), 36'h0);
      finish_test();
   end
endmodule // sram_byte_write_mask_bench
